// *** shared/rscp_pkg.sv ***
// Purpose: Shared constants and types for the radio serial configuration port
// Assumes: System clock of 20 MHz on both ends
// Notes:   Link frames are one direction bit, two address bits, then bytes MSB first
package rscp_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;

    // Link timing in ns, then derived cycle counts (least times round up)
    localparam int T_SCLK_HI_NS = 90;
    localparam int T_SCLK_LO_NS = 90;
    localparam int T_SEL_SETUP_NS = 1000;
    localparam int T_SEL_LO_NS = 90;
    localparam int SCLK_HI_CYC = (T_SCLK_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // One extra low cycle covers the read synchroniser delay
    localparam int SCLK_LO_CYC = (T_SCLK_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int SEL_SETUP_CYC = (T_SEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEL_LO_CYC = (T_SEL_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Recovered bit clock rate
    localparam int RBC_RATE_BPS = 19200;
    localparam int RBC_HALF_CYC = CLK_HZ / (2 * RBC_RATE_BPS);

    // Frame layout
    localparam int HDR_BITS = 3;
    localparam int BYTE_BITS = 8;
    localparam int ADDR_W = 2;
    localparam int N_REGS = 4;
    localparam int FRAME_BITS = HDR_BITS + 2 * BYTE_BITS;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [1:0] ADDR_FIRST = 2'h0;
    localparam logic [1:0] ADDR_SECOND = 2'h1;

    // Reset values and control bit positions
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int FCB_RECOVERY_BIT = 0;
    localparam int FCB_SLEEP_BIT = 7;

    // Command byte pairs
    localparam logic [7:0] FCB_RX_EXT = 8'h00;
    localparam logic [7:0] SCB_RX_EXT = 8'h00;
    localparam logic [7:0] FCB_RX_INT = 8'h01;
    localparam logic [7:0] SCB_RX_INT = 8'h04;
    localparam logic [7:0] FCB_TX = 8'h40;
    localparam logic [7:0] SCB_TX = 8'h20;
    localparam logic [7:0] FCB_SLEEP = 8'h80;
    localparam logic [7:0] SCB_SLEEP = 8'h00;

    typedef enum logic [2:0] {
        RSCP_CMD_RX_EXT = 3'h0,
        RSCP_CMD_RX_INT = 3'h1,
        RSCP_CMD_TX = 3'h2,
        RSCP_CMD_SLEEP = 3'h3,
        RSCP_CMD_READ = 3'h4
    } rscp_cmd_e;
endpackage

// *** shared/rscp_if.sv ***
// Purpose: Three-wire configuration link between host and radio
// Assumes: Data line pulled high when nobody drives it
// Notes:   Wire level resolved here from both enables
`timescale 1ns/1ps
`default_nettype none
interface rscp_if;
    logic sel;
    logic sclk;
    logic host_dat_o;
    logic host_dat_oe;
    logic dev_dat_o;
    logic dev_dat_oe;
    logic dat;

    assign dat = dev_dat_oe ? dev_dat_o : (host_dat_oe ? host_dat_o : 1'b1);

    modport host (
        output sel,
        output sclk,
        output host_dat_o,
        output host_dat_oe,
        input dat
    );
    modport dev (
        input sel,
        input sclk,
        input dat,
        output dev_dat_o,
        output dev_dat_oe
    );
endinterface
`default_nettype wire

// *** hw/rscp_dev.sv ***
// Purpose: Radio end of the serial configuration port
// Assumes: Link logic clocked by the host-made shift clock
// Notes:   Control registers live on the link clock, copies on the system clock
//
// Summary of operation
// - Data line is bidirectional in serial mode
// - Every eight write data bits commit a control register
// - Write bits sampled on shift clock rising edge
// - Read bits launched on rising, host captures at the end of the low phase
// - Shift clock ignored while select is low
// - No drive or sample while select low
// - Power-on with select low gives legacy mode
// - First select high switches to serial mode
// - Select rising wakes the radio from sleep
// - External recovery receive uses all-zero bytes
// - Internal recovery receive uses bytes 01, 04
// - Recovered clock runs until recovery bit cleared
`timescale 1ns/1ps
`default_nettype none
module rscp_dev (
    // System side
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Link
    rscp_if.dev link,
    // Receiver data path
    input wire logic i_start_symbol,
    input wire logic i_slicer_bit,
    // Status and control
    output logic o_serial_mode,
    output logic o_sleep,
    output logic [7:0] o_first_control_byte,
    output logic [7:0] o_second_control_byte,
    output logic o_recovered_bit_clock,
    output logic o_recovered_bit_data
);
    import rscp_pkg::*;

    // Link clock domain
    logic frame_rst_n;
    logic [1:0] hdr_cnt_ff;
    logic rw_ff;
    logic [1:0] addr_ff;
    logic [2:0] bidx_ff;
    logic [6:0] win_ff;
    logic [7:0] rout_ff;
    logic dout_ff;
    logic doe_ff;
    logic [7:0] regs_ff [N_REGS];
    logic [7:0] hold_byte_ff;
    logic [1:0] hold_addr_ff;
    logic tgl_ff;
    logic in_data;
    logic last_bit;
    logic [1:0] nxt_addr;

    // System clock domain
    logic tgl_s1_ff;
    logic tgl_s2_ff;
    logic tgl_s3_ff;
    logic sel_s1_ff;
    logic sel_s2_ff;
    logic sel_s3_ff;
    logic serial_ff;
    logic sleep_ff;
    logic [7:0] fcb_ff;
    logic [7:0] scb_ff;
    logic commit_seen;
    logic sel_rise;
    logic rbc_act_ff;
    logic [9:0] rbc_cnt_ff;
    logic rbc_ff;
    logic rbd_ff;

    // Frame state held in reset while select is low
    assign frame_rst_n = i_nrst & link.sel;
    assign in_data = (hdr_cnt_ff == 2'(HDR_BITS));
    assign last_bit = (bidx_ff == 3'(BYTE_BITS - 1));
    assign nxt_addr = addr_ff + 2'h1;

    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            hdr_cnt_ff <= 2'h0;
            rw_ff <= RW_WRITE;
            addr_ff <= ADDR_FIRST;
            bidx_ff <= 3'h0;
        end else if (!in_data) begin
            hdr_cnt_ff <= hdr_cnt_ff + 2'h1;
            if (hdr_cnt_ff == 2'h0) begin
                rw_ff <= link.dat;
            end else if (hdr_cnt_ff == 2'h1) begin
                addr_ff[1] <= link.dat;
            end else begin
                addr_ff[0] <= link.dat;
            end
        end else begin
            bidx_ff <= bidx_ff + 3'h1;
            if (last_bit) begin
                addr_ff <= nxt_addr;
            end
        end
    end

    // Incoming byte assembly
    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            win_ff <= 7'h00;
        end else if (in_data && rw_ff == RW_WRITE) begin
            win_ff <= {win_ff[5:0], link.dat};
        end
    end

    // Control registers and commit handoff
    always_ff @(posedge link.sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < N_REGS; i++) begin
                regs_ff[i] <= CTRL_RESET;
            end
            hold_byte_ff <= CTRL_RESET;
            hold_addr_ff <= ADDR_FIRST;
            tgl_ff <= 1'b0;
        end else if (link.sel && in_data && rw_ff == RW_WRITE && last_bit) begin
            regs_ff[addr_ff] <= {win_ff, link.dat};
            hold_byte_ff <= {win_ff, link.dat};
            hold_addr_ff <= addr_ff;
            tgl_ff <= ~tgl_ff;
        end
    end

    // Read launch on the rising edge
    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rout_ff <= CTRL_RESET;
            dout_ff <= 1'b0;
            doe_ff <= 1'b0;
        end else if (!in_data) begin
            if (hdr_cnt_ff == 2'h2) begin
                rout_ff <= regs_ff[{addr_ff[1], link.dat}];
            end
        end else if (rw_ff == RW_READ) begin
            doe_ff <= 1'b1;
            dout_ff <= rout_ff[7];
            if (last_bit) begin
                rout_ff <= regs_ff[nxt_addr];
            end else begin
                rout_ff <= {rout_ff[6:0], 1'b0};
            end
        end
    end

    assign link.dev_dat_o = dout_ff;
    assign link.dev_dat_oe = doe_ff & link.sel;

    // Synchronisers into the system domain
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            tgl_s1_ff <= 1'b0;
            tgl_s2_ff <= 1'b0;
            tgl_s3_ff <= 1'b0;
            sel_s1_ff <= 1'b0;
            sel_s2_ff <= 1'b0;
            sel_s3_ff <= 1'b0;
        end else begin
            tgl_s1_ff <= tgl_ff;
            tgl_s2_ff <= tgl_s1_ff;
            tgl_s3_ff <= tgl_s2_ff;
            sel_s1_ff <= link.sel;
            sel_s2_ff <= sel_s1_ff;
            sel_s3_ff <= sel_s2_ff;
        end
    end

    assign commit_seen = tgl_s2_ff ^ tgl_s3_ff;
    assign sel_rise = sel_s2_ff & ~sel_s3_ff;

    // Control mode
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            serial_ff <= 1'b0;
        end else if (sel_s2_ff) begin
            serial_ff <= 1'b1;
        end
    end

    // Control byte copies
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            fcb_ff <= CTRL_RESET;
            scb_ff <= CTRL_RESET;
        end else if (commit_seen) begin
            if (hold_addr_ff == ADDR_FIRST) begin
                fcb_ff <= hold_byte_ff;
            end
            if (hold_addr_ff == ADDR_SECOND) begin
                scb_ff <= hold_byte_ff;
            end
        end
    end

    // Sleep entered by command, left on select rising
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            sleep_ff <= 1'b0;
        end else if (sel_rise) begin
            sleep_ff <= 1'b0;
        end else if (commit_seen && hold_addr_ff == ADDR_FIRST) begin
            sleep_ff <= hold_byte_ff[FCB_SLEEP_BIT];
        end
    end

    // Recovered bit clock
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rbc_act_ff <= 1'b0;
        end else if (!fcb_ff[FCB_RECOVERY_BIT]) begin
            rbc_act_ff <= 1'b0;
        end else if (i_start_symbol && !sleep_ff) begin
            rbc_act_ff <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rbc_cnt_ff <= 10'h000;
            rbc_ff <= 1'b0;
            rbd_ff <= 1'b0;
        end else if (!rbc_act_ff) begin
            rbc_cnt_ff <= 10'h000;
            rbc_ff <= 1'b0;
        end else if (rbc_cnt_ff == 10'(RBC_HALF_CYC - 1)) begin
            rbc_cnt_ff <= 10'h000;
            rbc_ff <= ~rbc_ff;
            if (!rbc_ff) begin
                rbd_ff <= i_slicer_bit;
            end
        end else begin
            rbc_cnt_ff <= rbc_cnt_ff + 10'h001;
        end
    end

    assign o_serial_mode = serial_ff;
    assign o_sleep = sleep_ff;
    assign o_first_control_byte = fcb_ff;
    assign o_second_control_byte = scb_ff;
    assign o_recovered_bit_clock = rbc_ff;
    assign o_recovered_bit_data = rbd_ff;
endmodule
`default_nettype wire

// *** hw/rscp_host.sv ***
// Purpose: Host end that drives select and shift clock and runs frames
// Assumes: Shift clock derived from the system clock
// Notes:   Every frame carries address zero and two bytes
`timescale 1ns/1ps
`default_nettype none
module rscp_host (
    // System side
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Link
    rscp_if.host link,
    // Command request
    input wire logic i_start,
    input wire rscp_pkg::rscp_cmd_e i_cmd,
    // Results
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_rdata0,
    output logic [7:0] o_rdata1
);
    import rscp_pkg::*;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_SETUP = 5'b00010,
        S_HIGH = 5'b00100,
        S_LOW = 5'b01000,
        S_GAP = 5'b10000
    } rscp_state_e;

    rscp_state_e state_ff;
    logic [4:0] cnt_ff;
    logic [4:0] bitn_ff;
    logic [18:0] tx_ff;
    logic [15:0] rx_ff;
    logic rd_ff;
    logic sel_ff;
    logic sclk_ff;
    logic oe_ff;
    logic done_ff;
    logic dat_s1_ff;
    logic dat_s2_ff;
    logic [7:0] ld_fcb;
    logic [7:0] ld_scb;

    always_comb begin
        ld_fcb = FCB_RX_EXT;
        ld_scb = SCB_RX_EXT;
        unique case (i_cmd)
            RSCP_CMD_RX_INT: begin
                ld_fcb = FCB_RX_INT;
                ld_scb = SCB_RX_INT;
            end
            RSCP_CMD_TX: begin
                ld_fcb = FCB_TX;
                ld_scb = SCB_TX;
            end
            RSCP_CMD_SLEEP: begin
                ld_fcb = FCB_SLEEP;
                ld_scb = SCB_SLEEP;
            end
            default: begin
                ld_fcb = FCB_RX_EXT;
                ld_scb = SCB_RX_EXT;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            dat_s1_ff <= 1'b1;
            dat_s2_ff <= 1'b1;
        end else begin
            dat_s1_ff <= link.dat;
            dat_s2_ff <= dat_s1_ff;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= S_IDLE;
            cnt_ff <= 5'h00;
            bitn_ff <= 5'h00;
            tx_ff <= 19'h00000;
            rx_ff <= 16'h0000;
            rd_ff <= 1'b0;
            sel_ff <= 1'b0;
            sclk_ff <= 1'b0;
            oe_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                S_IDLE: begin
                    if (i_start) begin
                        rd_ff <= (i_cmd == RSCP_CMD_READ);
                        tx_ff <= {(i_cmd == RSCP_CMD_READ) ? RW_READ : RW_WRITE,
                                  ADDR_FIRST, ld_fcb, ld_scb};
                        sel_ff <= 1'b1;
                        oe_ff <= 1'b1;
                        cnt_ff <= 5'h00;
                        bitn_ff <= 5'h00;
                        state_ff <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    if (cnt_ff == 5'(SEL_SETUP_CYC - 1)) begin
                        cnt_ff <= 5'h00;
                        sclk_ff <= 1'b1;
                        state_ff <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    if (cnt_ff == 5'(SCLK_HI_CYC - 1)) begin
                        cnt_ff <= 5'h00;
                        sclk_ff <= 1'b0;
                        bitn_ff <= bitn_ff + 5'h01;
                        tx_ff <= {tx_ff[17:0], 1'b0};
                        if (rd_ff && bitn_ff == 5'(HDR_BITS - 1)) begin
                            oe_ff <= 1'b0;
                        end
                        state_ff <= S_LOW;
                    end
                end
                S_LOW: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    if (cnt_ff == 5'(SCLK_LO_CYC - 1)) begin
                        cnt_ff <= 5'h00;
                        if (rd_ff && bitn_ff > 5'(HDR_BITS)) begin
                            rx_ff <= {rx_ff[14:0], dat_s2_ff};
                        end
                        if (bitn_ff == 5'(FRAME_BITS)) begin
                            sel_ff <= 1'b0;
                            oe_ff <= 1'b0;
                            state_ff <= S_GAP;
                        end else begin
                            sclk_ff <= 1'b1;
                            state_ff <= S_HIGH;
                        end
                    end
                end
                S_GAP: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    if (cnt_ff == 5'(SEL_LO_CYC - 1)) begin
                        cnt_ff <= 5'h00;
                        done_ff <= 1'b1;
                        state_ff <= S_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.sel = sel_ff;
    assign link.sclk = sclk_ff;
    assign link.host_dat_o = tx_ff[18];
    assign link.host_dat_oe = oe_ff;
    assign o_busy = (state_ff != S_IDLE);
    assign o_done = done_ff;
    assign o_rdata0 = rx_ff[15:8];
    assign o_rdata1 = rx_ff[7:0];
endmodule
`default_nettype wire

// *** bench/rscp_link_properties.sv ***
// Purpose: Concurrent checks on the three-wire configuration link
// Assumes: Link signals sampled on the host system clock
// Notes:   Instantiated beside the link interface, no bind
`timescale 1ns/1ps
`default_nettype none
module rscp_link_properties (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Link signals
    input wire logic sel,
    input wire logic sclk,
    input wire logic host_dat_o,
    input wire logic host_dat_oe,
    input wire logic dev_dat_o,
    input wire logic dev_dat_oe,
    input wire logic dat
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    chk_idle_quiet: assert property (!sel |-> !dev_dat_oe && !sclk)
        else $error("link active while select low");
    chk_no_contention: assert property (!(dev_dat_oe && host_dat_oe))
        else $error("both ends drive the data line");
    chk_select_setup: assert property ($rose(sel) |-> !sclk [*8])
        else $error("shift clock too soon after select");
    chk_clock_in_frame: assert property ($rose(sclk) |-> sel ##1 sclk ##1 !sclk)
        else $error("shift clock pulse outside frame or wrong width");
    chk_launch_on_rise: assert property (
        (dev_dat_oe && $past(dev_dat_oe) && $changed(dev_dat_o)) |-> $rose(sclk))
        else $error("read bit launched off the rising edge");
    chk_stable_at_fall: assert property (($fell(sclk) && dev_dat_oe) |-> $stable(dat))
        else $error("read bit not stable at falling edge");
    chk_drive_start: assert property (
        $rose(dev_dat_oe) |-> $rose(sclk) && !$past(host_dat_oe))
        else $error("device drive not at a rising edge after host release");
    chk_write_held: assert property ((sclk && host_dat_oe) |-> $stable(host_dat_o))
        else $error("write bit changed while shift clock high");
endmodule
`default_nettype wire

// *** bench/test_radio_serial_config_port.sv ***
// Purpose: Self-checking bench joining host and radio ends of the link
// Assumes: 20 MHz system clock, shift clock made by the host end
// Notes:   Each scenario is a task that drives and judges
`timescale 1ns/1ps
`default_nettype none
module test_radio_serial_config_port;
    import rscp_pkg::*;
    logic i_clk_sys;
    logic i_nrst;
    logic i_start;
    rscp_cmd_e i_cmd;
    logic i_start_symbol;
    logic i_slicer_bit;
    logic o_busy, o_done, o_serial_mode, o_sleep, o_rbc, o_rbd;
    logic [7:0] o_rdata0, o_rdata1, o_fcb, o_scb;
    int miscompares = 0;
    int samples_checked = 0;

    rscp_if rscp_if_i ();
    rscp_host rscp_host_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .link(rscp_if_i.host),
        .i_start(i_start), .i_cmd(i_cmd), .o_busy(o_busy), .o_done(o_done),
        .o_rdata0(o_rdata0), .o_rdata1(o_rdata1));
    rscp_dev rscp_dev_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .link(rscp_if_i.dev),
        .i_start_symbol(i_start_symbol), .i_slicer_bit(i_slicer_bit),
        .o_serial_mode(o_serial_mode), .o_sleep(o_sleep), .o_first_control_byte(o_fcb),
        .o_second_control_byte(o_scb), .o_recovered_bit_clock(o_rbc),
        .o_recovered_bit_data(o_rbd));
    rscp_link_properties rscp_link_properties_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .sel(rscp_if_i.sel), .sclk(rscp_if_i.sclk), .host_dat_o(rscp_if_i.host_dat_o),
        .host_dat_oe(rscp_if_i.host_dat_oe), .dev_dat_o(rscp_if_i.dev_dat_o),
        .dev_dat_oe(rscp_if_i.dev_dat_oe), .dat(rscp_if_i.dat));

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One host command, bounded wait for completion
    task automatic run_cmd(input rscp_cmd_e c);
        int n;
        @(posedge i_clk_sys);
        i_start <= 1'b1;
        i_cmd <= c;
        @(posedge i_clk_sys);
        i_start <= 1'b0;
        @(negedge i_clk_sys);
        check({6'h00, o_busy, rscp_if_i.sel}, 8'h03);
        n = 0;
        while (o_done !== 1'b1 && n < 400) begin
            @(negedge i_clk_sys);
            n++;
        end
        check({7'h00, o_done}, 8'h01);
        repeat (4) @(negedge i_clk_sys);
        check({6'h00, o_busy, rscp_if_i.sel}, 8'h00);
    endtask

    // Bounded wait for a recovered clock level
    task automatic wait_rbc(input logic lvl, input int lim);
        int n;
        n = 0;
        while (o_rbc !== lvl && n < lim) begin
            @(negedge i_clk_sys);
            n++;
        end
        check({7'h00, o_rbc}, {7'h00, lvl});
    endtask

    task automatic test_reset_state();
        @(negedge i_clk_sys);
        check({7'h00, o_serial_mode}, 8'h00);
        check({7'h00, o_sleep}, 8'h00);
        check(o_fcb, CTRL_RESET);
        check({7'h00, o_rbc}, 8'h00);
    endtask

    task automatic test_write_cmds();
        rscp_cmd_e cmds [3] = '{RSCP_CMD_RX_EXT, RSCP_CMD_RX_INT, RSCP_CMD_TX};
        logic [7:0] fcbs [3] = '{FCB_RX_EXT, FCB_RX_INT, FCB_TX};
        logic [7:0] scbs [3] = '{SCB_RX_EXT, SCB_RX_INT, SCB_TX};
        for (int i = 0; i < 3; i++) begin
            run_cmd(cmds[i]);
            check({7'h00, o_serial_mode}, 8'h01);
            check(o_fcb, fcbs[i]);
            check(o_scb, scbs[i]);
        end
    endtask

    task automatic test_read_back();
        run_cmd(RSCP_CMD_READ);
        check(o_rdata0, FCB_TX);
        check(o_rdata1, SCB_TX);
        check(o_fcb, FCB_TX);
    endtask

    task automatic test_sleep_wake();
        run_cmd(RSCP_CMD_SLEEP);
        check({7'h00, o_sleep}, 8'h01);
        run_cmd(RSCP_CMD_READ);
        check({7'h00, o_sleep}, 8'h00);
        check(o_rdata0, FCB_SLEEP);
        check(o_rdata1, SCB_SLEEP);
    endtask

    task automatic test_recovered_clock();
        int highs;
        run_cmd(RSCP_CMD_RX_INT);
        @(posedge i_clk_sys);
        i_slicer_bit <= 1'b1;
        i_start_symbol <= 1'b1;
        @(posedge i_clk_sys);
        i_start_symbol <= 1'b0;
        wait_rbc(1'b1, 1200);
        check({7'h00, o_rbd}, 8'h01);
        @(posedge i_clk_sys);
        i_slicer_bit <= 1'b0;
        wait_rbc(1'b0, 1200);
        wait_rbc(1'b1, 1200);
        check({7'h00, o_rbd}, 8'h00);
        run_cmd(RSCP_CMD_RX_EXT);
        highs = 0;
        repeat (1100) begin
            @(negedge i_clk_sys);
            if (o_rbc !== 1'b0) highs++;
        end
        check({7'h00, (highs != 0)}, 8'h00);
    endtask

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        i_nrst = 1'b0;
        i_start = 1'b0;
        i_cmd = RSCP_CMD_RX_EXT;
        i_start_symbol = 1'b0;
        i_slicer_bit = 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        test_reset_state();
        test_write_cmds();
        test_read_back();
        test_sleep_wake();
        test_recovered_clock();
        tally_and_finish();
    end
endmodule
`default_nettype wire
